/* common/adc_link_pkg.sv */
// Shared constants and types for both ends of the stereo converter link.
// How it works
// (RULE1) Host feeds master clock at 256/384/512 fs.
// (RULE2) Device detects the master clock ratio itself.
// (RULE3) 384 or 512 ratios divide to 256 fs.
// (RULE4) The 256 fs tick runs decimator and modulator.
// (RULE5) Master clock runs before reset release.
// (RULE6) Hold reset 1024 master clocks, output zero.
// (RULE7) Output zero until 18436 sample periods pass.
// (RULE8) Host drives bit and word clocks; device data.
// (RULE9) Left-justified uses 64, 48 or 32 bits.
// (RULE10) I2S uses 64 or 48 bit clocks.
// (RULE11) Format low left-justified, high I2S, MSB first.
// (RULE12) Host holds format low until power-on done.
// (RULE13) Data changes after bit clock fall, word edge.
// (RULE14) Host changes word clock away from bit rise.
// (RULE15) Word clock stays locked to master clock.
// (RULE16) Drift over six bits halts, sends bipolar zero.
// (RULE17) Drift under five bits changes nothing.
// (RULE18) Decimate 64 fs bitstream to 16-bit samples.
// (RULE19) High-pass filter removes DC normally.
// (RULE20) Bypass input low filters, high passes through.
// (RULE21) Pass-through keeps DC and offset.
// (RULE22) Left and right share one data line.
// (RULE23) Left-justified MSB at edge; I2S one later.
// (RULE24) Bits after sixteen in a slot are zero.
package adc_link_pkg;
   localparam int WORD_BITS = 16;
   localparam int POR_MCLKS = 1024;
   localparam int VALID_PERIODS = 18436;
   localparam int DECIM_RATIO = 64;
   localparam int FIFO_WORDS = 32;
   localparam logic [6:0] DRIFT_LIMIT = 7'h06;
   localparam logic [9:0] RATIO_SPLIT_LO = 10'h140;
   localparam logic [9:0] RATIO_SPLIT_HI = 10'h1c0;
   localparam logic [15:0] BIPOLAR_ZERO_CODE = 16'h0000;
   localparam logic [6:0] ONES_MID = 7'h20;
   localparam int HPF_SHIFT = 8;
   localparam int HOST_FMT_HOLD = 1100;

   typedef enum logic [1:0]
   {
      RATIO_256 = 2'b00,
      RATIO_384 = 2'b01,
      RATIO_512 = 2'b10
   } ratio_e;

   typedef enum logic [1:0]
   {
      ST_POR = 2'b00,
      ST_WARM = 2'b01,
      ST_RUN = 2'b11,
      ST_LOST = 2'b10
   } dev_state_e;
endpackage

/* common/adc_link_if.sv */
// Pins between the converter device and its audio host controller.
`timescale 1ns/100ps
`default_nettype none
interface adc_link_if;
   logic master_clock_in;
   logic bit_clock;
   logic word_select_clock;
   logic serial_data;
   logic format_select;
   logic filter_bypass_select;

   modport dev_mp
   (
      input master_clock_in,
      input bit_clock,
      input word_select_clock,
      input format_select,
      input filter_bypass_select,
      output serial_data
   );

   modport host_mp
   (
      output master_clock_in,
      output bit_clock,
      output word_select_clock,
      output format_select,
      output filter_bypass_select,
      input serial_data
   );
endinterface
`default_nettype wire

/* rtl/adc_device_end.sv */
// Converter device end: sample FIFO, clock detect, decimator and serializer.
`timescale 1ns/100ps
`default_nettype none
module sample_fifo
   #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 32
   )
   (
   input wire logic i_mclk,
   input wire logic i_arst_n,
   input wire logic i_in_valid,
   output logic o_in_ready,
   input wire logic [WIDTH-1:0] i_in_data,
   output logic o_out_valid,
   input wire logic i_out_ready,
   output logic [WIDTH-1:0] o_out_data
   );
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wr_r;
   logic [AW:0] rd_r;
   wire full = (wr_r[AW] != rd_r[AW]) && (wr_r[AW-1:0] == rd_r[AW-1:0]);
   wire empty = (wr_r == rd_r);
   wire push = i_in_valid && !full;
   wire pop = i_out_ready && !empty;

   assign o_in_ready = !full;
   assign o_out_valid = !empty;
   assign o_out_data = mem[rd_r[AW-1:0]];

   always_ff @(posedge i_mclk)
   begin
      if (push)
         mem[wr_r[AW-1:0]] <= i_in_data;
   end

   always_ff @(posedge i_mclk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         wr_r <= '0;
         rd_r <= '0;
      end
      else
      begin
         wr_r <= wr_r + (AW+1)'(push);
         rd_r <= rd_r + (AW+1)'(pop);
      end
   end
endmodule

module adc_device_end
   import adc_link_pkg::*;
   #(
   parameter int VALID_WAIT = VALID_PERIODS,
   parameter int FIFO_DEPTH = FIFO_WORDS
   )
   (
   input wire logic i_mclk,
   input wire logic i_arst_n,
   adc_link_if.dev_mp link,
   input wire logic i_mod_left,
   input wire logic i_mod_right,
   output logic o_mod_strobe,
   output logic [1:0] o_ratio,
   output logic o_run,
   output logic o_sync_lost
   );
   function automatic ratio_e ratio_of(input logic [9:0] cnt);
      if (cnt < RATIO_SPLIT_LO)
         return RATIO_256;
      else if (cnt < RATIO_SPLIT_HI)
         return RATIO_384;
      else
         return RATIO_512;
   endfunction

   function automatic logic [15:0] to_pcm(input logic [6:0] ones);
      logic [6:0] d;
      d = ones - ONES_MID;
      if (ones >= 7'(DECIM_RATIO))
         return 16'h7fff;
      return {d[5:0], 10'h000};
   endfunction

   function automatic logic [15:0] sat16(input logic [16:0] v);
      if (v[16] != v[15])
         return v[16] ? 16'h8000 : 16'h7fff;
      return v[15:0];
   endfunction

   logic mci_q, bck_q, ws_q;
   logic [9:0] mcount_r;
   ratio_e ratio_r;
   logic [1:0] div_r;
   logic [7:0] phase_r;
   dev_state_e state_r;
   logic [10:0] por_r;
   logic [15:0] warm_r;
   logic [6:0] bsince_r, bper_cnt_r, bper_r, mark_r;
   logic align_r;
   logic [31:0] push_data_r, frame_r;
   logic push_valid_r;
   logic [5:0] bitcnt_r;
   logic dout_r;
   logic [6:0] ones_r [2];
   logic [15:0] pcm [2];

   wire mtick = link.master_clock_in && !mci_q;
   wire bck_rise = link.bit_clock && !bck_q;
   wire bck_fall = !link.bit_clock && bck_q;
   wire ws_edge = link.word_select_clock != ws_q;
   wire ws_rise = link.word_select_clock && !ws_q;
   wire run = state_r == ST_RUN;
   // Master-clock ticks kept so that 256 fs survives: all at 256, two of three at 384, every other one at 512.
   wire tick256 = mtick && ((ratio_r == RATIO_256) ||
      (ratio_r == RATIO_384 && div_r != 2'd2) ||
      (ratio_r == RATIO_512 && div_r == 2'd0)); // RULE3
   wire mod_tick = tick256 && phase_r[1:0] == 2'b11; // RULE4
   wire sample_tick = tick256 && phase_r == 8'hff; // RULE4
   wire [6:0] mark_diff = bsince_r - mark_r;
   wire [6:0] drift_abs = mark_diff[6] ? 7'(-mark_diff) : mark_diff;
   wire [6:0] drift_wrap = bper_r - drift_abs;
   wire [6:0] drift = (drift_wrap < drift_abs) ? drift_wrap : drift_abs;
   wire drift_bad = ws_rise && !align_r && drift > DRIFT_LIMIT; // RULE16 RULE17
   wire in_ready, out_valid;
   wire [31:0] out_data;
   wire fmt = link.format_select;
   wire left_slot = fmt ? !link.word_select_clock : link.word_select_clock;
   wire left_start = ws_edge && left_slot;
   wire [5:0] bitcnt_nxt = ws_edge ? 6'd0 :
      (bck_fall && bitcnt_r != 6'h3f) ? bitcnt_r + 6'd1 : bitcnt_r;
   wire [5:0] bit_idx = fmt ? bitcnt_nxt - 6'd1 : bitcnt_nxt; // RULE23
   wire [31:0] frame_nxt = left_start ?
      (out_valid ? out_data : '0) : frame_r;
   wire [15:0] slot_word = left_slot ? frame_nxt[31:16] : frame_nxt[15:0]; // RULE22
   wire slot_bit = (bit_idx < 6'(WORD_BITS)) ?
      slot_word[4'd15 - bit_idx[3:0]] : 1'b0; // RULE24 RULE11

   genvar ch;
   generate
      for (ch = 0; ch < 2; ch++)
      begin : g_chan
         logic [23:0] dc_r;
         wire bit_in = (ch == 0) ? i_mod_left : i_mod_right;
         wire [6:0] ones_fin = ones_r[ch] + 7'(bit_in);
         wire [15:0] raw = to_pcm(ones_fin); // RULE18
         wire [15:0] dc_est = dc_r[23:8];
         wire [16:0] hp = {raw[15], raw} - {dc_est[15], dc_est};
         wire [23:0] dc_err = {raw, 8'h00} - dc_r;
         // Bypass takes raw ahead of the DC tracker, which keeps running, so offset reaches the output.
         assign pcm[ch] = link.filter_bypass_select ? raw : sat16(hp); // RULE19 RULE20 RULE21
         always_ff @(posedge i_mclk or negedge i_arst_n)
         begin
            if (!i_arst_n)
            begin
               ones_r[ch] <= '0;
               dc_r <= '0;
            end
            else if (sample_tick || (ws_rise && align_r))
            begin
               ones_r[ch] <= '0;
               if (sample_tick)
                  dc_r <= dc_r + {{HPF_SHIFT{dc_err[23]}}, dc_err[23:HPF_SHIFT]}; // RULE19
            end
            else if (mod_tick)
               ones_r[ch] <= ones_fin; // RULE18
         end
      end
   endgenerate

   sample_fifo #(.WIDTH(32), .DEPTH(FIFO_DEPTH)) u_fifo
   (
      .i_mclk(i_mclk),
      .i_arst_n(i_arst_n),
      .i_in_valid(push_valid_r),
      .o_in_ready(in_ready),
      .i_in_data(push_data_r),
      .o_out_valid(out_valid),
      .i_out_ready(left_start),
      .o_out_data(out_data)
   );

   always_ff @(posedge i_mclk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         mci_q <= 1'b0;
         bck_q <= 1'b0;
         // The host idles the word clock high; a low value here fakes an edge.
         ws_q <= 1'b1;
         mcount_r <= '0;
         ratio_r <= RATIO_256;
         div_r <= '0;
         phase_r <= '0;
      end
      else
      begin
         mci_q <= link.master_clock_in;
         bck_q <= link.bit_clock;
         ws_q <= link.word_select_clock;
         if (ws_rise)
         begin
            mcount_r <= 10'(mtick);
            ratio_r <= ratio_of(mcount_r); // RULE2
         end
         else if (mtick && mcount_r != 10'h3ff)
            mcount_r <= mcount_r + 10'd1;
         if (mtick)
            div_r <= ((ratio_r == RATIO_384 && div_r == 2'd2) ||
               (ratio_r == RATIO_512 && div_r == 2'd1) ||
               ratio_r == RATIO_256) ? 2'd0 : div_r + 2'd1; // RULE3
         if (ws_rise && align_r)
            phase_r <= '0;
         else if (tick256)
            phase_r <= phase_r + 8'd1;
      end
   end

   // Word-clock position, in bit clocks, measured against the internal frame.
   always_ff @(posedge i_mclk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         bsince_r <= '0;
         bper_cnt_r <= '0;
         bper_r <= 7'h40;
         mark_r <= '0;
      end
      else
      begin
         if (sample_tick || (ws_rise && align_r))
            bsince_r <= '0;
         else if (bck_rise)
            bsince_r <= bsince_r + 7'd1;
         if (ws_rise)
         begin
            bper_cnt_r <= '0;
            bper_r <= bper_cnt_r;
            mark_r <= align_r ? 7'd0 : bsince_r;
         end
         else if (bck_rise)
            bper_cnt_r <= bper_cnt_r + 7'd1;
      end
   end

   always_ff @(posedge i_mclk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         state_r <= ST_POR;
         por_r <= '0;
         warm_r <= '0;
         align_r <= 1'b1;
      end
      else
      begin
         case (state_r)
            ST_POR:
            begin
               if (mtick)
                  por_r <= por_r + 11'd1;
               if (por_r == 11'(POR_MCLKS))
                  state_r <= ST_WARM; // RULE6 RULE5
            end
            ST_WARM:
            begin
               if (ws_rise)
                  align_r <= 1'b0;
               if (drift_bad)
                  state_r <= ST_LOST;
               else if (sample_tick && !align_r)
               begin
                  warm_r <= warm_r + 16'd1;
                  if (warm_r == 16'(VALID_WAIT - 1))
                     state_r <= ST_RUN; // RULE7
               end
            end
            ST_RUN:
            begin
               if (drift_bad)
               begin
                  state_r <= ST_LOST; // RULE16
                  align_r <= 1'b1;
               end
            end
            ST_LOST:
            begin
               align_r <= 1'b1;
               if (ws_rise && align_r)
               begin
                  state_r <= ST_RUN;
                  align_r <= 1'b0;
               end
            end
            default:
               state_r <= ST_POR;
         endcase
      end
   end

   // A sample still waiting on a full FIFO is replaced by the newer one.
   always_ff @(posedge i_mclk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         push_valid_r <= 1'b0;
         push_data_r <= '0;
         frame_r <= '0;
         bitcnt_r <= 6'h3f;
         dout_r <= 1'b0;
      end
      else
      begin
         if (sample_tick && run)
         begin
            push_valid_r <= 1'b1;
            push_data_r <= {pcm[0], pcm[1]};
         end
         else if (in_ready)
            push_valid_r <= 1'b0;
         frame_r <= frame_nxt;
         bitcnt_r <= bitcnt_nxt;
         if (!run)
            dout_r <= BIPOLAR_ZERO_CODE[0]; // RULE6 RULE7 RULE16
         else if (ws_edge || bck_fall)
            dout_r <= slot_bit; // RULE13 RULE8
      end
   end

   assign link.serial_data = dout_r; // RULE8
   assign o_mod_strobe = mod_tick;
   assign o_ratio = ratio_r;
   assign o_run = run;
   assign o_sync_lost = state_r == ST_LOST;
endmodule
`default_nettype wire

/* rtl/adc_host_end.sv */
// Audio host end: makes master, bit and word clocks and collects samples.
`timescale 1ns/100ps
`default_nettype none
module adc_host_end
   import adc_link_pkg::*;
   #(
   parameter int RATIO = 384,
   parameter int BITS_PER_FRAME = 64,
   parameter int HALF_DIV = 2
   )
   (
   input wire logic i_mclk,
   input wire logic i_arst_n,
   adc_link_if.host_mp link,
   input wire logic i_format,
   input wire logic i_bypass,
   output logic [15:0] o_left,
   output logic [15:0] o_right,
   output logic o_valid
   );
   localparam int BPER = RATIO / BITS_PER_FRAME;

   logic [7:0] hdiv_r;
   logic mc_r, bck_r, ws_r, fmt_ok_r, valid_r;
   logic [9:0] mcnt_r;
   logic [7:0] bsub_r;
   logic [10:0] hold_r;
   logic [5:0] rx_cnt_r;
   logic [15:0] shift_r, left_r, right_r;

   wire mc_rise = (hdiv_r == 8'(HALF_DIV - 1)) && !mc_r;
   wire [9:0] mcnt_nxt = (mcnt_r == 10'(RATIO - 1)) ? 10'd0 : mcnt_r + 10'd1;
   wire [7:0] bsub_nxt = (bsub_r == 8'(BPER - 1)) ? 8'd0 : bsub_r + 8'd1;
   wire bck_up = mc_rise && bsub_nxt == 8'(BPER / 2);
   wire ws_nxt = mcnt_nxt < 10'(RATIO / 2);
   wire ws_flip = mc_rise && ws_nxt != ws_r;
   wire fmt = i_format && fmt_ok_r;
   wire [5:0] rx_idx = fmt ? rx_cnt_r - 6'd1 : rx_cnt_r;
   wire rx_left = fmt ? !ws_r : ws_r;
   wire [15:0] shift_nxt = {shift_r[14:0], link.serial_data};

   always_ff @(posedge i_mclk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         hdiv_r <= '0;
         mc_r <= 1'b0;
         mcnt_r <= '0;
         bsub_r <= '0;
         bck_r <= 1'b0;
         ws_r <= 1'b1;
         hold_r <= '0;
         fmt_ok_r <= 1'b0;
      end
      else
      begin
         hdiv_r <= (hdiv_r == 8'(HALF_DIV - 1)) ? 8'd0 : hdiv_r + 8'd1;
         if (hdiv_r == 8'(HALF_DIV - 1))
            mc_r <= !mc_r; // RULE1 RULE5
         if (mc_rise)
         begin
            mcnt_r <= mcnt_nxt;
            bsub_r <= bsub_nxt;
            // Word clock moves only with a bit clock fall, clear of rises.
            bck_r <= bsub_nxt >= 8'(BPER / 2); // RULE9 RULE10
            ws_r <= ws_nxt; // RULE14 RULE15
            if (hold_r != 11'(HOST_FMT_HOLD))
               hold_r <= hold_r + 11'd1;
         end
         fmt_ok_r <= hold_r == 11'(HOST_FMT_HOLD); // RULE12
      end
   end

   always_ff @(posedge i_mclk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         rx_cnt_r <= '0;
         shift_r <= '0;
         left_r <= '0;
         right_r <= '0;
         valid_r <= 1'b0;
      end
      else
      begin
         valid_r <= 1'b0;
         if (ws_flip)
            rx_cnt_r <= '0;
         else if (bck_up)
         begin
            if (rx_cnt_r != 6'h3f)
               rx_cnt_r <= rx_cnt_r + 6'd1;
            if (rx_idx < 6'(WORD_BITS))
               shift_r <= shift_nxt; // RULE11
            if (rx_idx == 6'(WORD_BITS - 1))
            begin
               if (rx_left)
                  left_r <= shift_nxt;
               else
               begin
                  right_r <= shift_nxt;
                  valid_r <= 1'b1;
               end
            end
         end
      end
   end

   assign link.master_clock_in = mc_r;
   assign link.bit_clock = bck_r; // RULE8
   assign link.word_select_clock = ws_r;
   assign link.format_select = fmt;
   assign link.filter_bypass_select = i_bypass;
   assign o_left = left_r;
   assign o_right = right_r;
   assign o_valid = valid_r;
endmodule
`default_nettype wire

/* verif/adc_link_chk.sv */
// Concurrent checks on the link pins and the device status flags.
`timescale 1ns/100ps
`default_nettype none
module adc_link_chk
   #(
   parameter int VALID_WAIT = 4,
   parameter int BITS = 64,
   parameter logic [1:0] EXP_RATIO = 2'h1
   )
   (
   input wire logic i_mclk,
   input wire logic i_arst_n,
   input wire logic master_clock_in,
   input wire logic bit_clock,
   input wire logic word_select_clock,
   input wire logic serial_data,
   input wire logic format_select,
   input wire logic [1:0] o_ratio,
   input wire logic o_run,
   input wire logic o_sync_lost
   );
   logic [10:0] mck_r;
   logic [7:0] frm_r;
   logic [7:0] rise_r;
   logic [5:0] fall_r;
   logic ws_seen_r;
   logic run_seen_r;

   default clocking cb @(posedge i_mclk);
   endclocking
   default disable iff (!i_arst_n);

   // Counters other than rise_r saturate so long runs never wrap into a false antecedent; rise_r clears on each word clock rise.
   always_ff @(posedge i_mclk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         mck_r <= 11'h0;
         frm_r <= 8'h0;
         rise_r <= 8'h0;
         fall_r <= 6'h0;
         ws_seen_r <= 1'b0;
         run_seen_r <= 1'b0;
      end
      else
      begin
         if ($rose(master_clock_in) && mck_r != 11'h7ff)
            mck_r <= mck_r + 11'h1;
         if ($rose(word_select_clock) && mck_r >= 11'h400 && frm_r != 8'hff)
            frm_r <= frm_r + 8'h1;
         if ($rose(word_select_clock))
            rise_r <= 8'h0;
         else if ($rose(bit_clock))
            rise_r <= rise_r + 8'h1;
         if ($changed(word_select_clock))
            fall_r <= 6'h0;
         else if ($fell(bit_clock) && fall_r != 6'h3f)
            fall_r <= fall_r + 6'h1;
         ws_seen_r <= ws_seen_r | $rose(word_select_clock);
         run_seen_r <= run_seen_r | o_run;
      end
   end

   por_hold_a: assert property (mck_r < 11'h400 |-> !o_run)
      else $error("run before power-on count");
   valid_wait_a: assert property (frm_r < VALID_WAIT |-> !o_run)
      else $error("run before warm-up periods");
   run_comes_a: assert property (frm_r == 8'(VALID_WAIT + 3) |-> o_run)
      else $error("run missing after warm-up");
   zero_out_a: assert property (!o_run [*3] |-> !serial_data)
      else $error("data not zero outside run");
   ratio_a: assert property (o_run |-> o_ratio == EXP_RATIO)
      else $error("wrong clock ratio");
   ws_fall_a: assert property ($changed(word_select_clock) |-> $fell(bit_clock))
      else $error("word clock off bit fall");
   frame_len_a: assert property ($rose(word_select_clock) && ws_seen_r
      |-> rise_r == 8'(BITS))
      else $error("bit clocks per frame wrong");
   tail_zero_a: assert property (fall_r >= 6'd18 |-> !serial_data)
      else $error("slot tail not zero");
   fmt_hold_a: assert property (mck_r < 11'h400 |-> !format_select)
      else $error("format raised during power-on");
   data_edge_a: assert property ($changed(serial_data) |->
      ($past(bit_clock, 4) && !$past(bit_clock, 1)) ||
      ($past(word_select_clock, 4) != $past(word_select_clock, 1)) ||
      ($past(o_run, 3) != o_run))
      else $error("data moved off clock edges");
   no_drift_a: assert property (run_seen_r |-> !o_sync_lost)
      else $error("lost sync on steady link");
endmodule
`default_nettype wire

/* verif/stereo_adc_serial_output_ctrl_bench.sv */
// Bench: host and device on one link, and a second device under drift.
`timescale 1ns/100ps
`default_nettype none
module stereo_adc_serial_output_ctrl_bench;
   import adc_link_pkg::*;
   localparam int WAIT_N = 4;
   localparam int FRM = 1536;
   logic i_mclk = 1'b0;
   logic i_arst_n = 1'b0;
   logic mod_l = 1'b1;
   logic mod_r = 1'b0;
   logic alt = 1'b0;
   logic fmt_sel = 1'b1;
   logic byp_sel = 1'b1;
   logic strobe, strobe_b, run, run_b, lost, lost_b, valid;
   logic [1:0] ratio, ratio_b;
   logic [15:0] left, right;
   logic [10:0] pos_r = 11'h0;
   logic [10:0] jump = 11'h0;
   logic [1:0] div_r = 2'h0;
   int err_total = 0;
   int checks_done = 0;
   adc_link_if lnk();
   adc_link_if lnk_b();

   always #4 i_mclk = ~i_mclk;
   always @(posedge i_mclk)
   begin
      mod_l <= alt ? mod_l ^ strobe : 1'b1;
      mod_r <= alt ? mod_r ^ strobe : 1'b0;
      div_r <= div_r + 2'h1;
      pos_r <= 11'((pos_r + jump + 11'h1) % 11'd1536);
   end
   // Jumps are whole bits, so only the word phase moves against the clock.
   assign lnk_b.master_clock_in = div_r[1];
   assign lnk_b.bit_clock = (pos_r % 11'd24) >= 11'd12;
   assign lnk_b.word_select_clock = pos_r < 11'd768;
   assign lnk_b.format_select = lnk.format_select;
   assign lnk_b.filter_bypass_select = byp_sel;

   adc_device_end #(.VALID_WAIT(WAIT_N), .FIFO_DEPTH(FIFO_WORDS))
      adc_device_end_inst (.i_mclk(i_mclk), .i_arst_n(i_arst_n), .link(lnk),
      .i_mod_left(mod_l), .i_mod_right(mod_r), .o_mod_strobe(strobe),
      .o_ratio(ratio), .o_run(run), .o_sync_lost(lost));
   adc_device_end #(.VALID_WAIT(WAIT_N), .FIFO_DEPTH(FIFO_WORDS))
      adc_device_end_b_inst (.i_mclk(i_mclk), .i_arst_n(i_arst_n),
      .link(lnk_b), .i_mod_left(mod_l), .i_mod_right(mod_r),
      .o_mod_strobe(strobe_b), .o_ratio(ratio_b), .o_run(run_b),
      .o_sync_lost(lost_b));
   adc_host_end #(.RATIO(384), .BITS_PER_FRAME(64), .HALF_DIV(2))
      adc_host_end_inst (.i_mclk(i_mclk), .i_arst_n(i_arst_n), .link(lnk),
      .i_format(fmt_sel), .i_bypass(byp_sel), .o_left(left),
      .o_right(right), .o_valid(valid));
   adc_link_chk #(.VALID_WAIT(WAIT_N), .BITS(64), .EXP_RATIO(2'h1))
      adc_link_chk_inst (.i_mclk(i_mclk), .i_arst_n(i_arst_n),
      .master_clock_in(lnk.master_clock_in), .bit_clock(lnk.bit_clock),
      .word_select_clock(lnk.word_select_clock),
      .serial_data(lnk.serial_data), .format_select(lnk.format_select),
      .o_ratio(ratio), .o_run(run), .o_sync_lost(lost));

   task automatic check(input string what, input logic [31:0] seen,
      input logic [31:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic finish_test();
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task automatic wait_frames(input int k);
      repeat (k * FRM) @(negedge i_mclk);
   endtask

   task automatic wait_valid();
      int k;
      for (k = 0; k < 2 * FRM && valid !== 1'b1; k++)
         @(negedge i_mclk);
      check("valid", valid, 1'b1);
   endtask

   // Reads the left slot straight off the wire at the receiver's edge.
   task automatic wire_word(input logic i2s, input logic [15:0] exp);
      logic [15:0] w;
      logic z;
      int k;
      w = 16'h0;
      z = 1'b1;
      if (i2s)
         @(negedge lnk.word_select_clock);
      else
         @(posedge lnk.word_select_clock);
      for (k = 0; k < 17 + i2s; k++)
      begin
         @(posedge lnk.bit_clock);
         if (k >= i2s && k < 16 + i2s)
            w = {w[14:0], lnk.serial_data};
         else if (k == 16 + i2s)
            z = lnk.serial_data;
      end
      check("wire word", w, exp);
      check("wire tail", z, 1'b0);
   endtask

   initial
   begin
      repeat (95000) @(posedge i_mclk);
      err_total++;
      finish_test();
   end

   initial
   begin
      int n;
      int k;
      repeat (16) @(posedge i_mclk);
      i_arst_n <= 1'b1;
      for (n = 0; n < 30000 && run !== 1'b1; n++)
         @(negedge i_mclk);
      check("run", run, 1'b1);
      check("ratio", ratio, RATIO_384);
      check("ratio b", ratio_b, RATIO_384);
      $display("test power up done");
      for (n = 0; n < 2; n++)
      begin
         @(posedge i_mclk);
         fmt_sel <= ~n[0];
         wait_frames(3);
         wire_word(~n[0], 16'h7fff);
         wait_valid();
         check("left", left, 16'h7fff);
         check("right", right, 16'h8000);
      end
      $display("test formats done");
      @(posedge i_mclk);
      alt <= 1'b1;
      wait_frames(3);
      wait_valid();
      check("mid left", left, 16'h0000);
      check("mid right", right, 16'h0000);
      @(posedge i_mclk);
      alt <= 1'b0;
      byp_sel <= 1'b0;
      wait_frames(3);
      wait_valid();
      check("dc cut", left < 16'h7fff && !left[15], 1'b1);
      @(posedge i_mclk);
      byp_sel <= 1'b1;
      wait_frames(2);
      wait_valid();
      check("bypass", left, 16'h7fff);
      $display("test filter done");
      check("b run", run_b, 1'b1);
      @(posedge i_mclk);
      jump <= 11'd72;
      @(posedge i_mclk);
      jump <= 11'h0;
      wait_frames(3);
      check("small drift", {run_b, lost_b}, 2'b10);
      @(posedge i_mclk);
      jump <= 11'd240;
      @(posedge i_mclk);
      jump <= 11'h0;
      for (n = 0; n < FRM + 64 && lost_b !== 1'b1; n++)
         @(negedge i_mclk);
      check("big drift", lost_b, 1'b1);
      repeat (4) @(negedge i_mclk);
      check("zero code", lnk_b.serial_data, BIPOLAR_ZERO_CODE[0]);
      for (n = 0; n < 8 * FRM && run_b !== 1'b1; n++)
         @(negedge i_mclk);
      check("resync", run_b, 1'b1);
      $display("test drift done");
      // One word per frame must cross the sample FIFO, none lost or doubled.
      k = 0;
      for (n = 0; n < 4 * FRM; n++)
      begin
         @(negedge i_mclk);
         k += int'(valid);
      end
      check("frames", k, 4);
      wait_valid();
      check("fifo left", left, 16'h7fff);
      check("fifo right", right, 16'h8000);
      $display("test stream done");
      finish_test();
   end
endmodule
`default_nettype wire
